// ==== hw/mfr_pkg.sv ====
// package: register map, fields and rate constants for the motion filter config
package mfr_pkg;
    // byte addresses (offsets are not multiples of four, so index * 4)
    localparam logic [7:0] IDX_RATE_DIV = 8'h19;
    localparam logic [7:0] IDX_GEN_CFG = 8'h1a;
    localparam logic [7:0] IDX_GYRO_CFG = 8'h1b;
    localparam logic [7:0] IDX_ACC_CFG = 8'h1c;
    localparam logic [7:0] IDX_ACC_FLT = 8'h1d;
    localparam logic [7:0] IDX_LP_WAKE = 8'h1e;
    localparam logic [7:0] IDX_MODE = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam logic [7:0] IDX_RATE = 8'h22;
    localparam logic [9:0] ADDR_RATE_DIV = {IDX_RATE_DIV, 2'b00};
    localparam logic [9:0] ADDR_GEN_CFG = {IDX_GEN_CFG, 2'b00};
    localparam logic [9:0] ADDR_GYRO_CFG = {IDX_GYRO_CFG, 2'b00};
    localparam logic [9:0] ADDR_ACC_CFG = {IDX_ACC_CFG, 2'b00};
    localparam logic [9:0] ADDR_ACC_FLT = {IDX_ACC_FLT, 2'b00};
    localparam logic [9:0] ADDR_LP_WAKE = {IDX_LP_WAKE, 2'b00};
    localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [9:0] ADDR_RATE = {IDX_RATE, 2'b00};
    // reset values
    localparam logic [7:0] RST_RATE_DIV = 8'h00;
    localparam logic [7:0] RST_GEN_CFG = 8'h00;
    localparam logic [7:0] RST_GYRO_CFG = 8'h00;
    localparam logic [7:0] RST_ACC_CFG = 8'h00;
    localparam logic [7:0] RST_ACC_FLT = 8'h00;
    localparam logic [7:0] RST_LP_WAKE = 8'h00;
    // writable bit masks; reserved bits read zero
    localparam logic [7:0] MASK_GEN_CFG = 8'h07;
    localparam logic [7:0] MASK_GYRO_CFG = 8'hfb;
    localparam logic [7:0] MASK_ACC_CFG = 8'hf8;
    localparam logic [7:0] MASK_ACC_FLT = 8'h0f;
    localparam logic [7:0] MASK_LP_WAKE = 8'h0f;
    // field positions
    localparam int GYRO_BYP_LSB = 0;
    localparam int RANGE_LSB = 3;
    localparam int ST_Z_BIT = 5;
    localparam int ACC_BYP_BIT = 3;
    localparam int SETTING_LSB = 0;
    localparam int WAKE_LSB = 0;
    localparam logic [3:0] WAKE_MAX_CODE = 4'hb;
    // internal rates in kHz
    localparam logic [5:0] RATE_32K = 6'h20;
    localparam logic [5:0] RATE_8K = 6'h08;
    localparam logic [5:0] RATE_4K = 6'h04;
    localparam logic [5:0] RATE_1K = 6'h01;
    // low-power fixed output bandwidth (Hz) and delay (ms)
    localparam logic [15:0] LP_BW_HZ = 16'h044c;
    localparam logic [7:0] LP_DELAY_MS = 8'h01;
    // clock: 250 MHz; 1 kHz tick period in cycles
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_MHZ * TICK_US;

    typedef enum logic [1:0] {
        MFR_GR_250, MFR_GR_500, MFR_GR_1000, MFR_GR_2000
    } mfr_gyro_range_t;
    typedef enum logic [1:0] {
        MFR_AR_2G, MFR_AR_4G, MFR_AR_8G, MFR_AR_16G
    } mfr_accel_range_t;

    typedef struct packed {
        logic [1:0] gyro_filter_choice;
        logic gyro_filter_active;
        logic [2:0] gyro_filter_setting;
        logic [5:0] gyro_rate_khz;
        logic divider_honoured;
        mfr_gyro_range_t gyro_range_select;
        mfr_accel_range_t accel_range_select;
        logic accel_filter_choice;
        logic [2:0] accel_filter_setting;
        logic [5:0] accel_rate_khz;
        logic [2:0] gyro_selftest;
        logic [2:0] accel_selftest;
        logic lowpower;
        logic [3:0] lowpower_wake_rate;
        logic wake_code_valid;
    } mfr_cfg_t;
endpackage

// ==== hw/mfr_rate_div.sv ====
// rate strobe: base tick divided by one plus the divider value
`timescale 1ns/10ps
`default_nettype none
module mfr_rate_div
    import mfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [7:0] divider,
    output logic strobe
);
    logic [31:0] tick_cnt_r;
    logic [7:0] div_cnt_r;
    logic tick;

    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst || tick) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // divider is compared live at each tick, so a new value applies at once; a count at or above it wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_r <= 8'h00;
            strobe <= 1'b0;
        end else begin
            strobe <= 1'b0;
            if (tick) begin
                if (!enable || div_cnt_r >= divider) begin
                    div_cnt_r <= 8'h00;
                    strobe <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/mfr_top.sv ====
// motion filter rate config: axi4-lite register file and decoded config
// Contract
// RULE1: gyro filter choice equals bitwise inverse of the bypass field.
// RULE2: gyro/temp filtering from setting plus bypass; setting used only if bypass zero.
// RULE3: bypass bit0 set, or bit1 alone, gives widest path at 32 kHz.
// RULE4: bypass zero: 8 kHz for settings 0 and 7, else 1 kHz.
// RULE5: gyro bypass at bits 1:0, bit 2 reserved.
// RULE6: gyro range bits 4:3 select 250/500/1000/2000 dps.
// RULE7: accel range bits 4:3 select 2/4/8/16 g; bits 2:0 reserved.
// RULE8: accel bypass bit 3, accel setting bits 2:0, bits 7:4 reserved.
// RULE9: normal mode accel rate 4 kHz if bypass set, else 1 kHz.
// RULE10: filtered output rate divided by one plus 8-bit divider.
// RULE11: low-power mode duty-cycles accel with accel filter choice zero.
// RULE12: wake-rate bits 3:0, codes 0-11 valid, 12-15 reserved.
// RULE13: low-power output bandwidth fixed about 1.1 kHz, delay 1 ms.
// RULE14: sample rate 1 kHz over one plus divider, only with settings 1-6.
// RULE15: gyro setting in general config bits 2:0, used when bypass zero.
// RULE16: per-axis self-test bits enable self-test on each axis.
// RULE17: software writes zero to reserved bits and avoids reserved codes.
`timescale 1ns/10ps
`default_nettype none
module mfr_top
    import mfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output mfr_cfg_t CFG,
    output logic SAMPLE_STROBE,
    output logic [15:0] LP_BANDWIDTH_HZ,
    output logic [7:0] LP_DELAY
);
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    logic [7:0] rate_div_r;
    logic [7:0] gen_cfg_r;
    logic [7:0] gyro_cfg_r;
    logic [7:0] acc_cfg_r;
    logic [7:0] acc_flt_r;
    logic [7:0] lp_wake_r;
    logic lowpower_r;
    logic [11:0] aw_addr_r;
    logic aw_have_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic w_have_r;
    logic do_write;
    logic wr_en;
    logic [2:0] gyro_st;
    logic [2:0] acc_st;
    logic [31:0] rdata_nxt;
    logic rd_hit;
    logic wr_hit;
    logic [1:0] byp;
    logic [2:0] gset;
    logic [5:0] grate;
    logic honour;
    logic strobe;
    mfr_cfg_t cfg_nxt;

    // address decode shared by read and write paths
    function automatic logic addr_mapped(input logic [11:0] a);
        logic [9:0] w;
        w = a[9:0];
        return (a[11:10] == 2'b00) && (w[1:0] == 2'b00) &&
            (w == ADDR_RATE_DIV || w == ADDR_GEN_CFG ||
             w == ADDR_GYRO_CFG || w == ADDR_ACC_CFG ||
             w == ADDR_ACC_FLT || w == ADDR_LP_WAKE ||
             w == ADDR_MODE || w == ADDR_STATUS || w == ADDR_RATE);
    endfunction

    // write channel capture: address and data in either order
    assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_have_r && !S_AXI_BVALID;
    assign do_write = aw_have_r && w_have_r && !S_AXI_BVALID;
    assign wr_hit = addr_mapped(aw_addr_r);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            w_have_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_r <= 1'b1;
            w_data_r <= S_AXI_WDATA[7:0];
            w_strb_r <= S_AXI_WSTRB[0];
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // register storage; only byte lane 0 carries data
    assign wr_en = do_write && w_strb_r && (aw_addr_r[11:10] == 2'b00);

    function automatic logic wr_sel(input logic [9:0] adr);
        return wr_en && (aw_addr_r[9:0] == adr);
    endfunction

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rate_div_r <= RST_RATE_DIV;
        end else if (wr_sel(ADDR_RATE_DIV)) begin
            rate_div_r <= w_data_r; // RULE10
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gen_cfg_r <= RST_GEN_CFG;
        end else if (wr_sel(ADDR_GEN_CFG)) begin
            gen_cfg_r <= w_data_r & MASK_GEN_CFG; // RULE15
        end
    end

    // reserved bits masked so they always read back zero
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gyro_cfg_r <= RST_GYRO_CFG;
        end else if (wr_sel(ADDR_GYRO_CFG)) begin
            gyro_cfg_r <= w_data_r & MASK_GYRO_CFG; // RULE5
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            acc_cfg_r <= RST_ACC_CFG;
        end else if (wr_sel(ADDR_ACC_CFG)) begin
            acc_cfg_r <= w_data_r & MASK_ACC_CFG; // RULE7
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            acc_flt_r <= RST_ACC_FLT;
        end else if (wr_sel(ADDR_ACC_FLT)) begin
            acc_flt_r <= w_data_r & MASK_ACC_FLT; // RULE8
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lp_wake_r <= RST_LP_WAKE;
        end else if (wr_sel(ADDR_LP_WAKE)) begin
            lp_wake_r <= w_data_r & MASK_LP_WAKE; // RULE12
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lowpower_r <= 1'b0;
        end else if (wr_sel(ADDR_MODE)) begin
            lowpower_r <= w_data_r[0];
        end
    end

    // read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_hit = addr_mapped(S_AXI_ARADDR);

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (S_AXI_ARADDR[9:0])
            ADDR_RATE_DIV: rdata_nxt[7:0] = rate_div_r;
            ADDR_GEN_CFG: rdata_nxt[7:0] = gen_cfg_r;
            ADDR_GYRO_CFG: rdata_nxt[7:0] = gyro_cfg_r;
            ADDR_ACC_CFG: rdata_nxt[7:0] = acc_cfg_r;
            ADDR_ACC_FLT: rdata_nxt[7:0] = acc_flt_r;
            ADDR_LP_WAKE: rdata_nxt[7:0] = lp_wake_r;
            ADDR_MODE: rdata_nxt[0] = lowpower_r;
            ADDR_STATUS: rdata_nxt[3:0] = {CFG.wake_code_valid,
                CFG.divider_honoured, CFG.gyro_filter_active,
                CFG.accel_filter_choice};
            ADDR_RATE: rdata_nxt[13:0] = {CFG.gyro_rate_khz, 2'b00,
                CFG.accel_rate_khz};
            default: rdata_nxt = 32'h0000_0000;
        endcase
        if (!rd_hit) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rdata_nxt;
            S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // self-test enables, one per axis; z sits lowest
    for (genvar ax = 0; ax < 3; ax++) begin : g_axis
        assign gyro_st[ax] = gyro_cfg_r[ST_Z_BIT + ax]; // RULE16
        assign acc_st[ax] = acc_cfg_r[ST_Z_BIT + ax]; // RULE16
    end

    // gyro path decode
    assign byp = gyro_cfg_r[GYRO_BYP_LSB +: 2];
    assign gset = gen_cfg_r[SETTING_LSB +: 3];
    assign honour = (byp == 2'b00) && (gset != 3'h0) && (gset != 3'h7);

    always_comb begin
        if (byp != 2'b00) begin
            grate = RATE_32K; // RULE3
        end else if (gset == 3'h0 || gset == 3'h7) begin
            grate = RATE_8K; // RULE4
        end else begin
            grate = RATE_1K; // RULE4
        end
    end

    always_comb begin
        cfg_nxt = '0;
        cfg_nxt.gyro_filter_choice = ~byp; // RULE1
        cfg_nxt.gyro_filter_active = (byp == 2'b00); // RULE2 RULE15
        cfg_nxt.gyro_filter_setting = (byp == 2'b00) ? gset : 3'h0; // RULE2
        cfg_nxt.gyro_rate_khz = grate;
        cfg_nxt.divider_honoured = honour; // RULE14
        cfg_nxt.gyro_range_select =
            mfr_gyro_range_t'(gyro_cfg_r[RANGE_LSB +: 2]); // RULE6
        cfg_nxt.accel_range_select =
            mfr_accel_range_t'(acc_cfg_r[RANGE_LSB +: 2]); // RULE7
        cfg_nxt.gyro_selftest = gyro_st; // RULE16
        cfg_nxt.accel_selftest = acc_st; // RULE16
        cfg_nxt.lowpower = lowpower_r; // RULE11
        cfg_nxt.lowpower_wake_rate = lp_wake_r[WAKE_LSB +: 4]; // RULE12
        // reserved codes are flagged, not remapped
        cfg_nxt.wake_code_valid =
            (lp_wake_r[WAKE_LSB +: 4] <= WAKE_MAX_CODE); // RULE12 RULE17
        if (lowpower_r) begin
            cfg_nxt.accel_filter_choice = 1'b0; // RULE11
            cfg_nxt.accel_filter_setting = 3'h0;
            cfg_nxt.accel_rate_khz = 6'h00;
        end else begin
            cfg_nxt.accel_filter_choice = ~acc_flt_r[ACC_BYP_BIT]; // RULE8
            cfg_nxt.accel_filter_setting = acc_flt_r[SETTING_LSB +: 3];
            cfg_nxt.accel_rate_khz = acc_flt_r[ACC_BYP_BIT] ?
                RATE_4K : RATE_1K; // RULE9
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CFG <= '0;
            LP_BANDWIDTH_HZ <= 16'h0000;
            LP_DELAY <= 8'h00;
        end else begin
            CFG <= cfg_nxt;
            LP_BANDWIDTH_HZ <= lowpower_r ? LP_BW_HZ : 16'h0000; // RULE13
            LP_DELAY <= lowpower_r ? LP_DELAY_MS : 8'h00; // RULE13
        end
    end

    // divider ignored unless the filtered 1 kHz gyro path is selected
    mfr_rate_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_div (
        .clk(SYS_CLK),
        .rst(RST),
        .enable(honour),
        .divider(rate_div_r),
        .strobe(strobe)
    ); // RULE10 RULE14

    assign SAMPLE_STROBE = strobe;
endmodule
`default_nettype wire

// ==== verification/mfr_top_chk.sv ====
// checker: decoded config and bus handshake relations of mfr_top
`timescale 1ns/10ps
`default_nettype none
module mfr_top_chk
    import mfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire mfr_cfg_t CFG,
    input wire logic SAMPLE_STROBE
);
    // cfg still reads zero just after reset, so wait two cycles
    logic [1:0] age_r;
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            age_r <= 2'h0;
        end else if (!age_r[1]) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence r_answer;
        S_AXI_RVALID ##0 !S_AXI_ARREADY;
    endsequence
    chk_choice_active: assert property (age_r[1] |->
        CFG.gyro_filter_active == (CFG.gyro_filter_choice == 2'b11))
        else $error("filter active flag disagrees with choice");
    chk_gyro_rate: assert property (age_r[1] |->
        CFG.gyro_rate_khz == ((CFG.gyro_filter_choice != 2'b11) ? RATE_32K :
        (CFG.gyro_filter_setting inside {3'h0, 3'h7}) ? RATE_8K : RATE_1K))
        else $error("gyro rate wrong");
    chk_accel_rate: assert property (age_r[1] && !CFG.lowpower |->
        CFG.accel_rate_khz == (CFG.accel_filter_choice ? RATE_1K : RATE_4K))
        else $error("accel rate wrong");
    chk_lp_choice: assert property (CFG.lowpower |->
        !CFG.accel_filter_choice && CFG.accel_rate_khz == 6'h00)
        else $error("low power accel choice not zero");
    chk_div_honour: assert property (age_r[1] |->
        CFG.divider_honoured == (CFG.gyro_filter_active &&
        !(CFG.gyro_filter_setting inside {3'h0, 3'h7})))
        else $error("divider honour flag wrong");
    chk_wake_valid: assert property (age_r[1] |->
        CFG.wake_code_valid == (CFG.lowpower_wake_rate <= WAKE_MAX_CODE))
        else $error("wake code valid flag wrong");
    chk_read_answer: assert property (ar_taken |=> r_answer)
        else $error("read answer not one cycle after address");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("read valid dropped early");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    // strobes come from whole ticks, so never closer than one tick
    chk_strobe_gap: assert property (
        TICK_CYCLES > 8 && SAMPLE_STROBE |=> !SAMPLE_STROBE [*8])
        else $error("sample strobes too close");
endmodule
bind mfr_top mfr_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
    .SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .CFG(CFG), .SAMPLE_STROBE(SAMPLE_STROBE)
);
`default_nettype wire

// ==== verification/mfr_top_tb_top.sv ====
// testbench: axi4-lite register access and decoded config of mfr_top
`timescale 1ns/10ps
`default_nettype none
module mfr_top_tb_top;
    import mfr_pkg::*;
    // short tick keeps divider runs to a few thousand cycles
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wr, bv, arr, rv, strobe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] lp_bw;
    logic [7:0] lp_dly;
    mfr_cfg_t cfg;
    int bad_count = 0, total_checks = 0, cyc = 0;
    logic [11:0] ad [7] = '{{2'b00, ADDR_GYRO_CFG}, {2'b00, ADDR_ACC_CFG},
        {2'b00, ADDR_ACC_FLT}, {2'b00, ADDR_LP_WAKE}, {2'b00, ADDR_GEN_CFG},
        {2'b00, ADDR_RATE_DIV}, {2'b00, ADDR_MODE}};
    logic [7:0] mk [7] = '{MASK_GYRO_CFG, MASK_ACC_CFG, MASK_ACC_FLT,
        MASK_LP_WAKE, MASK_GEN_CFG, 8'hff, 8'h01};
    logic [7:0] tg [5] = '{8'h01, 8'h06, 8'h00, 8'h07, 8'h03};
    logic [7:0] td [5] = '{8'h02, 8'hff, 8'h05, 8'h05, 8'h04};
    logic [7:0] sh [7];
    mfr_top #(.TICK_CYCLES(TICK)) uut (
        .SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .CFG(cfg), .SAMPLE_STROBE(strobe), .LP_BANDWIDTH_HZ(lp_bw),
        .LP_DELAY(lp_dly)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [63:0] e,
        input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // address and data offered together, bready raised after 0-3 cycles and held until the answer
    task automatic axw(input logic [11:0] a, input logic [7:0] d,
        input logic [1:0] er);
        int n;
        int dl;
        // late ready now and then, so the response must stand
        dl = $urandom_range(3);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= (dl == 0);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (n == dl) bready <= 1'b1;
        end while (!(bv && bready) && n < 40);
        bready <= 1'b0;
        check("bvalid", 64'h1, bv);
        check("bresp", er, bresp);
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        int dl;
        dl = $urandom_range(3);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= (dl == 0);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
            if (n == dl) rready <= 1'b1;
        end while (!(rv && rready) && n < 40);
        rready <= 1'b0;
        check("rvalid", 64'h1, rv);
        check("rresp", er, rresp);
        check("rdata", ed, rdata);
    endtask
    function automatic mfr_cfg_t exp_cfg();
        mfr_cfg_t c;
        logic lp;
        logic fix;
        lp = sh[6][0];
        fix = sh[4][2:0] inside {3'h0, 3'h7};
        c.gyro_filter_choice = ~sh[0][1:0];
        c.gyro_filter_active = (sh[0][1:0] == 2'h0);
        c.gyro_filter_setting = c.gyro_filter_active ? sh[4][2:0] : 3'h0;
        c.gyro_rate_khz = !c.gyro_filter_active ? RATE_32K :
            fix ? RATE_8K : RATE_1K;
        c.divider_honoured = c.gyro_filter_active && !fix;
        c.gyro_range_select = mfr_gyro_range_t'(sh[0][4:3]);
        c.accel_range_select = mfr_accel_range_t'(sh[1][4:3]);
        c.accel_filter_choice = !lp && !sh[2][3];
        c.accel_filter_setting = lp ? 3'h0 : sh[2][2:0];
        c.accel_rate_khz = lp ? 6'h00 : sh[2][3] ? RATE_4K : RATE_1K;
        c.gyro_selftest = sh[0][7:5];
        c.accel_selftest = sh[1][7:5];
        c.lowpower = lp;
        c.lowpower_wake_rate = sh[3][3:0];
        c.wake_code_valid = (sh[3][3:0] <= WAKE_MAX_CODE);
        return c;
    endfunction
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (strobe !== 1'b1 && c < 9000);
    endtask
    initial begin
        int c;
        int e;
        logic [7:0] d;
        int i;
        mfr_cfg_t ec;
        void'($urandom(79));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            sh[k] = 8'h00;
            axr(ad[k], 32'h0000_0000, 2'b00);
        end
        check("cfg", exp_cfg(), cfg);
        // all ones first so reserved bits must read back zero
        for (int k = 0; k < 40; k++) begin
            i = (k < 7) ? k : $urandom_range(6);
            d = (k < 7) ? 8'hff : (i == 3) ? 8'($urandom_range(WAKE_MAX_CODE)) :
                8'($urandom()) & mk[i];
            sh[i] = d & mk[i];
            axw(ad[i], d, 2'b00);
            axr(ad[i], {24'h00_0000, sh[i]}, 2'b00);
            repeat (2) @(posedge clk);
            check("cfg", exp_cfg(), cfg);
            check("lp_bw", sh[6][0] ? LP_BW_HZ : 16'h0000, lp_bw);
            check("lp_dly", sh[6][0] ? LP_DELAY_MS : 8'h00, lp_dly);
            ec = exp_cfg();
            axr({2'b00, ADDR_STATUS}, {28'h000_0000, ec.wake_code_valid,
                ec.divider_honoured, ec.gyro_filter_active,
                ec.accel_filter_choice}, 2'b00);
            axr({2'b00, ADDR_RATE}, {18'h0_0000, ec.gyro_rate_khz, 2'b00,
                ec.accel_rate_khz}, 2'b00);
        end
        axw(12'h400, 8'h5a, 2'b10);
        axr(12'h400, 32'h0000_0000, 2'b10);
        // mid-run reset must bring every register back to zero
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            sh[k] = 8'h00;
            axr(ad[k], 32'h0000_0000, 2'b00);
        end
        repeat (2) @(posedge clk);
        check("cfg", exp_cfg(), cfg);
        // last case bypasses the filter, so the divider must be ignored
        for (int j = 0; j < 5; j++) begin
            sh[0] = (j == 4) ? 8'h01 : 8'h00;
            sh[4] = tg[j];
            sh[5] = td[j];
            axw(ad[0], sh[0], 2'b00);
            axw(ad[4], sh[4], 2'b00);
            axw(ad[5], sh[5], 2'b00);
            e = exp_cfg().divider_honoured ? (1 + sh[5]) * TICK : TICK;
            gap(c);
            gap(c);
            check("strobe_gap", e, c);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
